/* File: hw/rsf_pkg.sv */
// constants, types and helpers shared by the reset source block
package rsf_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] RSF_REG_ADDR     = 8'hEF;
   localparam int         RSF_BIT_PIN      = 0;
   localparam int         RSF_BIT_POR      = 1;
   localparam int         RSF_BIT_MCD      = 2;
   localparam int         RSF_BIT_WDT      = 3;
   localparam int         RSF_BIT_SW       = 4;
   localparam int         RSF_BIT_CMP      = 5;
   localparam int         RSF_BIT_FERR     = 6;
   localparam int         RSF_BIT_USB      = 7;
   localparam logic [7:0] RSF_FLAGS_RESET  = 8'h02;
   localparam logic       RSF_VDD_EN_RESET = 1'b1;
   localparam logic [7:0] RSF_RDATA_RESET  = 8'h00;

   // ------------------------------------------------------------
   // flash limits
   // ------------------------------------------------------------
   localparam logic [15:0] RSF_LIMIT_32K   = 16'h7FFF;
   localparam logic [15:0] RSF_LIMIT_64K   = 16'hFBFF;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int RSF_CLK_MHZ       = 100;
   localparam int RSF_MCD_TIME_US   = 100;
   localparam int RSF_MCD_CYCLES    = RSF_MCD_TIME_US * RSF_CLK_MHZ;
   localparam int RSF_WDT_PRESCALE  = 12;
   localparam int RSF_WDT_TICKS     = 256;
   localparam int RSF_HOLD_CYCLES   = 16;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      RSF_ST_RUN  = 3'b001,
      RSF_ST_HOLD = 3'b010,
      RSF_ST_PIN  = 3'b100
   } rsf_state_type;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic rsf_over_limit(input logic [15:0] addr, input logic big);
      rsf_over_limit = big ? (addr > RSF_LIMIT_64K) : (addr > RSF_LIMIT_32K);
   endfunction

endpackage

/* File: hw/rsf_watchdog.sv */
// watchdog counter clocked by the reference clock divided by twelve
`timescale 1ns/1ps
`default_nettype none
module rsf_watchdog
(
   input  wire logic ref_clk_in,
   input  wire logic arst_n_in,
   input  wire logic ce_in,
   input  wire logic restart_in,
   input  wire logic enable_in,
   input  wire logic disable_in,
   input  wire logic kick_in,
   output logic      timeout_out,
   output logic      running_out
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic        en;
      logic [3:0]  pre;
      logic [15:0] cnt;
      logic        to;
   } rsf_wdt_state_type;

   rsf_wdt_state_type s_q;
   rsf_wdt_state_type s_d;
   logic              tick;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d    = s_q;
      s_d.to = 1'b0;
      tick   = (s_q.pre == 4'(rsf_pkg::RSF_WDT_PRESCALE - 1));
      s_d.pre = tick ? 4'h0 : 4'(s_q.pre + 4'h1);
      if (restart_in)
      begin
         // any reset leaves the watchdog running
         s_d.en  = 1'b1;
         s_d.pre = 4'h0;
         s_d.cnt = 16'h0000;
      end
      else
      begin
         if (disable_in)
            s_d.en = 1'b0;
         else if (enable_in)
            s_d.en = 1'b1;
         if (kick_in || !s_q.en)
            s_d.cnt = 16'h0000;
         else if (tick)
         begin
            if (s_q.cnt == 16'(rsf_pkg::RSF_WDT_TICKS - 1))
            begin
               s_d.cnt = 16'h0000;
               s_d.to  = 1'b1;
            end
            else
               s_d.cnt = 16'(s_q.cnt + 16'h0001);
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         s_q <= '{en: 1'b1, pre: 4'h0, cnt: 16'h0000, to: 1'b0};
      else if (ce_in)
         s_q <= s_d;
   end

   assign timeout_out = s_q.to;
   assign running_out = s_q.en;

endmodule
`default_nettype wire

/* File: hw/rsf_reset_source.sv */
// reset source collector with cause and enable register
`timescale 1ns/1ps
`default_nettype none
// Contract
// - any reset re-enables the watchdog, ticking at clock over twelve.
// - watchdog timeout causes system reset and sets bit 3 flag.
// - internal resets never drive or change the external reset pin.
// - enabled flash write above user limit causes flash error reset.
// - code read above user limit causes flash error reset.
// - branch fetch above user limit causes flash error reset.
// - flash access forbidden by security causes flash error reset.
// - flash write or erase with supply monitor off causes flash error reset.
// - bit 6 reads 1 only after flash error reset, read only.
// - bit 7 flags last USB reset; writing it enables USB source.
// - enabled USB source resets when bus power matches polarity select.
// - enabled clock loss detector resets after 100 us without clock edge.
// - bit 5 enables active low comparator reset and flags it.
// - pin reset sets bit 0 flag on entry.
module rsf_reset_source
#(
   parameter int MCD_LIMIT = rsf_pkg::RSF_MCD_CYCLES
)
(
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  sfr_addr_in,
   input  wire logic        sfr_wr_in,
   input  wire logic        sfr_rd_in,
   input  wire logic        sfr_rmw_in,
   input  wire logic [7:0]  sfr_wdata_in,
   output logic      [7:0]  sfr_rdata_out,
   input  wire logic        pin_rst_n_in,
   input  wire logic        vdd_low_in,
   input  wire logic        system_clock_signal_in,
   input  wire logic        comparator_out_in,
   input  wire logic        vbus_in,
   input  wire logic        bus_power_polarity_select_in,
   input  wire logic        flash_size_64k_in,
   input  wire logic        flash_write_enable_in,
   input  wire logic        external_move_op_wr_in,
   input  wire logic [15:0] external_move_op_addr_in,
   input  wire logic        code_read_op_in,
   input  wire logic [15:0] code_read_op_addr_in,
   input  wire logic        branch_fetch_in,
   input  wire logic [15:0] branch_fetch_addr_in,
   input  wire logic        flash_security_block_in,
   input  wire logic        flash_wr_erase_in,
   input  wire logic        vdd_monitor_on_in,
   input  wire logic        wdt_enable_in,
   input  wire logic        wdt_disable_in,
   input  wire logic        wdt_kick_in,
   output logic             sys_reset_out,
   output logic             wdt_running_out
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      rsf_pkg::rsf_state_type st;
      logic [7:0]             flags;
      logic                   usb_en;
      logic                   cmp_en;
      logic                   mcd_en;
      logic                   vdd_en;
      logic [4:0]             hold_cnt;
      logic [15:0]            mcd_cnt;
      logic [1:0]             pin_s;
      logic [1:0]             vdd_s;
      logic [1:0]             sclk_s;
      logic [1:0]             cmp_s;
      logic [1:0]             vbus_s;
      logic                   sclk_prev;
      logic [7:0]             rdata;
      logic                   sys_rst;
   } rsf_state_reg_type;

   localparam logic [15:0] MCD_LIM16 = 16'(MCD_LIMIT);
   localparam logic [4:0]  HOLD_LAST = 5'(rsf_pkg::RSF_HOLD_CYCLES - 1);

   // power-on value: inside the stretch, only the supply cause recorded
   localparam rsf_state_reg_type RESET_STATE = '{
      st        : rsf_pkg::RSF_ST_HOLD,
      flags     : rsf_pkg::RSF_FLAGS_RESET,
      usb_en    : 1'b0,
      cmp_en    : 1'b0,
      mcd_en    : 1'b0,
      vdd_en    : rsf_pkg::RSF_VDD_EN_RESET,
      hold_cnt  : 5'h00,
      mcd_cnt   : 16'h0000,
      pin_s     : 2'h3,
      vdd_s     : 2'h0,
      sclk_s    : 2'h0,
      cmp_s     : 2'h3,
      vbus_s    : 2'h0,
      sclk_prev : 1'b0,
      rdata     : rsf_pkg::RSF_RDATA_RESET,
      sys_rst   : 1'b1
   };

   rsf_state_reg_type s_q;
   rsf_state_reg_type s_d;
   logic [7:0]        trig;
   logic              sel;
   logic              wr_ok;
   logic              ferr;
   logic              ferr_ext;
   logic              ferr_code;
   logic              ferr_fetch;
   logic              ferr_sec;
   logic              ferr_supply;
   logic [7:0]        rmw_view;
   logic              wdt_timeout;
   logic              wdt_restart;

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   // restart held for the whole stretch so every reset starts a fresh count
   assign wdt_restart = s_q.sys_rst;

   rsf_watchdog u_wdt
   (
      .ref_clk_in  (ref_clk_in),
      .arst_n_in   (arst_n_in),
      .ce_in       (ce_in),
      .restart_in  (wdt_restart),
      .enable_in   (wdt_enable_in),
      .disable_in  (wdt_disable_in),
      .kick_in     (wdt_kick_in),
      .timeout_out (wdt_timeout),
      .running_out (wdt_running_out)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;

      // ------------------------------------------------------------
      // input synchronisers
      // ------------------------------------------------------------
      // pins cross in by two flops; only the second stage is looked at
      s_d.pin_s     = {s_q.pin_s[0], pin_rst_n_in};
      s_d.vdd_s     = {s_q.vdd_s[0], vdd_low_in};
      s_d.sclk_s    = {s_q.sclk_s[0], system_clock_signal_in};
      s_d.cmp_s     = {s_q.cmp_s[0], comparator_out_in};
      s_d.vbus_s    = {s_q.vbus_s[0], vbus_in};
      s_d.sclk_prev = s_q.sclk_s[1];

      // ------------------------------------------------------------
      // clock loss detector
      // ------------------------------------------------------------
      // clock loss: count our cycles since the last rising edge
      if (!s_q.mcd_en || (s_q.st != rsf_pkg::RSF_ST_RUN) ||
          (s_q.sclk_s[1] && !s_q.sclk_prev))
         s_d.mcd_cnt = 16'h0000;
      else if (s_q.mcd_cnt < MCD_LIM16)
         s_d.mcd_cnt = 16'(s_q.mcd_cnt + 16'h0001);

      // ------------------------------------------------------------
      // register access decode
      // ------------------------------------------------------------
      sel   = (sfr_addr_in == rsf_pkg::RSF_REG_ADDR);
      wr_ok = sel && sfr_wr_in && (s_q.st == rsf_pkg::RSF_ST_RUN);

      // ------------------------------------------------------------
      // flash fault decode
      // ------------------------------------------------------------
      ferr_ext    = flash_write_enable_in && external_move_op_wr_in &&
                    rsf_pkg::rsf_over_limit(external_move_op_addr_in, flash_size_64k_in);
      ferr_code   = code_read_op_in &&
                    rsf_pkg::rsf_over_limit(code_read_op_addr_in, flash_size_64k_in);
      ferr_fetch  = branch_fetch_in &&
                    rsf_pkg::rsf_over_limit(branch_fetch_addr_in, flash_size_64k_in);
      ferr_sec    = flash_security_block_in;
      ferr_supply = flash_wr_erase_in && !vdd_monitor_on_in;
      ferr        = ferr_ext || ferr_code || ferr_fetch || ferr_sec || ferr_supply;

      // ------------------------------------------------------------
      // cause vector
      // ------------------------------------------------------------
      // the pin is only ever sensed; no internal cause drives it
      trig = 8'h00;
      trig[rsf_pkg::RSF_BIT_PIN]  = !s_q.pin_s[1];
      trig[rsf_pkg::RSF_BIT_POR]  = s_q.vdd_en && s_q.vdd_s[1];
      trig[rsf_pkg::RSF_BIT_MCD]  = s_q.mcd_en && (s_q.mcd_cnt >= MCD_LIM16);
      trig[rsf_pkg::RSF_BIT_WDT]  = wdt_timeout;
      trig[rsf_pkg::RSF_BIT_SW]   = wr_ok && sfr_wdata_in[rsf_pkg::RSF_BIT_SW];
      trig[rsf_pkg::RSF_BIT_CMP]  = s_q.cmp_en && !s_q.cmp_s[1];
      trig[rsf_pkg::RSF_BIT_FERR] = ferr;
      // polarity select is same-clock logic and needs no synchroniser
      trig[rsf_pkg::RSF_BIT_USB]  = s_q.usb_en &&
                                    (s_q.vbus_s[1] == bus_power_polarity_select_in);

      // ------------------------------------------------------------
      // register write: enables only, flags are hardware owned
      // ------------------------------------------------------------
      // flags are never written here, so no set and clear can collide
      if (wr_ok)
      begin
         s_d.usb_en = sfr_wdata_in[rsf_pkg::RSF_BIT_USB];
         s_d.cmp_en = sfr_wdata_in[rsf_pkg::RSF_BIT_CMP];
         s_d.mcd_en = sfr_wdata_in[rsf_pkg::RSF_BIT_MCD];
         s_d.vdd_en = sfr_wdata_in[rsf_pkg::RSF_BIT_POR];
      end

      // ------------------------------------------------------------
      // reset sequencing
      // ------------------------------------------------------------
      case (s_q.st)
         rsf_pkg::RSF_ST_RUN:
         begin
            if (|trig)
            begin
               // every cause firing together is recorded; others read 0
               s_d.flags    = trig;
               s_d.usb_en   = 1'b0;
               s_d.cmp_en   = 1'b0;
               s_d.mcd_en   = 1'b0;
               s_d.hold_cnt = 5'h00;
               s_d.st       = trig[rsf_pkg::RSF_BIT_PIN] ? rsf_pkg::RSF_ST_PIN
                                                         : rsf_pkg::RSF_ST_HOLD;
            end
         end
         rsf_pkg::RSF_ST_PIN:
         begin
            // held as long as the pin is low, then the usual stretch
            if (s_q.pin_s[1])
               s_d.st = rsf_pkg::RSF_ST_HOLD;
         end
         rsf_pkg::RSF_ST_HOLD:
         begin
            // fixed stretch gives the core the same settle time for every cause except a pin reset inside the stretch, which resumes the count
            if (!s_q.pin_s[1])
            begin
               s_d.flags[rsf_pkg::RSF_BIT_PIN] = 1'b1;
               s_d.st = rsf_pkg::RSF_ST_PIN;
            end
            else if (s_q.hold_cnt == HOLD_LAST)
               s_d.st = rsf_pkg::RSF_ST_RUN;
            else
               s_d.hold_cnt = 5'(s_q.hold_cnt + 5'h01);
         end
         default:
         begin
            // an unknown code falls back into the stretch
            s_d.st = rsf_pkg::RSF_ST_HOLD;
         end
      endcase

      // registered so a decode glitch never reaches the reset tree
      s_d.sys_rst = (s_d.st != rsf_pkg::RSF_ST_RUN);

      // ------------------------------------------------------------
      // register read
      // ------------------------------------------------------------
      // rmw must not turn a recorded cause into an enable, nor re-fire bit 4
      rmw_view                        = 8'h00;
      rmw_view[rsf_pkg::RSF_BIT_USB]  = s_q.usb_en;
      rmw_view[rsf_pkg::RSF_BIT_FERR] = s_q.flags[rsf_pkg::RSF_BIT_FERR];
      rmw_view[rsf_pkg::RSF_BIT_CMP]  = s_q.cmp_en;
      rmw_view[rsf_pkg::RSF_BIT_SW]   = 1'b0;
      rmw_view[rsf_pkg::RSF_BIT_WDT]  = s_q.flags[rsf_pkg::RSF_BIT_WDT];
      rmw_view[rsf_pkg::RSF_BIT_MCD]  = s_q.mcd_en;
      rmw_view[rsf_pkg::RSF_BIT_POR]  = s_q.vdd_en;
      rmw_view[rsf_pkg::RSF_BIT_PIN]  = s_q.flags[rsf_pkg::RSF_BIT_PIN];

      if (sel && sfr_rd_in)
      begin
         if (sfr_rmw_in)
            s_d.rdata = rmw_view;
         else
            s_d.rdata = s_q.flags;
      end
      else
         s_d.rdata = rsf_pkg::RSF_RDATA_RESET;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         s_q <= RESET_STATE;
      else if (ce_in)
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign sfr_rdata_out = s_q.rdata;
   assign sys_reset_out = s_q.sys_rst;

endmodule
`default_nettype wire

/* File: test/rsf_reset_source_monitor.sv */
// checker watching the reset source block ports
`timescale 1ns/1ps
`default_nettype none
module rsf_reset_source_monitor
(
   input wire logic        ref_clk_in,
   input wire logic        arst_n_in,
   input wire logic        ce_in,
   input wire logic [7:0]  sfr_addr_in,
   input wire logic        sfr_wr_in,
   input wire logic        sfr_rd_in,
   input wire logic        sfr_rmw_in,
   input wire logic [7:0]  sfr_wdata_in,
   input wire logic [7:0]  sfr_rdata_out,
   input wire logic        flash_size_64k_in,
   input wire logic        flash_write_enable_in,
   input wire logic        external_move_op_wr_in,
   input wire logic [15:0] external_move_op_addr_in,
   input wire logic        code_read_op_in,
   input wire logic [15:0] code_read_op_addr_in,
   input wire logic        branch_fetch_in,
   input wire logic [15:0] branch_fetch_addr_in,
   input wire logic        flash_security_block_in,
   input wire logic        flash_wr_erase_in,
   input wire logic        vdd_monitor_on_in,
   input wire logic        sys_reset_out,
   input wire logic        wdt_running_out
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   wire logic [15:0] lim = flash_size_64k_in ? rsf_pkg::RSF_LIMIT_64K : rsf_pkg::RSF_LIMIT_32K;
   wire logic        run = ce_in && !sys_reset_out;
   wire logic        hit = sfr_addr_in == rsf_pkg::RSF_REG_ADDR;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   chk_soft_force:
      assert property (run && sfr_wr_in && hit && sfr_wdata_in[4] |=> sys_reset_out)
      else $error("software force gave no reset");
   chk_ext_write:
      assert property (run && flash_write_enable_in && external_move_op_wr_in
         && external_move_op_addr_in > lim |=> sys_reset_out)
      else $error("flash write above limit gave no reset");
   chk_code_read:
      assert property (run && code_read_op_in && code_read_op_addr_in > lim |=> sys_reset_out)
      else $error("code read above limit gave no reset");
   chk_branch_fetch:
      assert property (run && branch_fetch_in && branch_fetch_addr_in > lim |=> sys_reset_out)
      else $error("branch above limit gave no reset");
   chk_secure_block:
      assert property (run && flash_security_block_in |=> sys_reset_out)
      else $error("blocked access gave no reset");
   chk_monitor_off:
      assert property (run && flash_wr_erase_in && !vdd_monitor_on_in |=> sys_reset_out)
      else $error("write with monitor off gave no reset");
   chk_wdt_rearm:
      assert property ($fell(sys_reset_out) |-> wdt_running_out)
      else $error("watchdog not running after reset");
   chk_rmw_force_zero:
      assert property (ce_in && sfr_rd_in && sfr_rmw_in && hit |=> !sfr_rdata_out[4])
      else $error("rmw read shows force flag");

   cover property (run && flash_security_block_in);
   cover property ($fell(wdt_running_out));
   cover property (run && sfr_wr_in && hit && sfr_wdata_in[4]);
endmodule
bind rsf_reset_source rsf_reset_source_monitor mon_i (.*);
`default_nettype wire

/* File: test/rsf_reset_source_bench.sv */
// self-checking bench for the reset source block
`timescale 1ns/1ps
`default_nettype none
module rsf_reset_source_bench;
   localparam int CLOCK_LOSS_DETECTOR = 50;
   logic ref_clk_in = 0, arst_n_in = 0, ce_in = 1, sfr_wr_in = 0, sfr_rd_in = 0;
   logic sfr_rmw_in = 0, pin_rst_n_in = 1, vdd_low_in = 0, system_clock_signal_in = 0;
   logic comparator_out_in = 1, vbus_in = 0, bus_power_polarity_select_in = 0;
   logic flash_size_64k_in = 0, flash_write_enable_in = 0, external_move_op_wr_in = 0;
   logic code_read_op_in = 0, branch_fetch_in = 0, flash_security_block_in = 0;
   logic flash_wr_erase_in = 0, vdd_monitor_on_in = 1, wdt_enable_in = 0;
   logic wdt_disable_in = 0, wdt_kick_in = 0, sys_reset_out, wdt_running_out, sclk_run = 1;
   logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out, rd;
   logic [15:0] external_move_op_addr_in = 16'h0000, code_read_op_addr_in = 16'h0000;
   logic [15:0] branch_fetch_addr_in = 16'h0000;
   int          fails = 0, samples_checked = 0, cyc = 0;

   rsf_reset_source #(.MCD_LIMIT(CLOCK_LOSS_DETECTOR)) uut (.*);

   // ------------------------------------------------------------
   // clocks and timeout
   // ------------------------------------------------------------
   always #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      if (sclk_run)
         system_clock_signal_in <= ~system_clock_signal_in;
      if (cyc == 20000)
      begin
         fails = fails + 1;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // any reset seen in the whole window counts, not just at its end
   task automatic quiet(input string what, input int n);
      logic seen;
      seen = 1'b0;
      repeat (n)
      begin
         tick(1);
         seen = seen | sys_reset_out;
      end
      chk(what, {7'h00, seen}, 8'h00);
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge ref_clk_in);
      sfr_addr_in <= rsf_pkg::RSF_REG_ADDR;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      sfr_wr_in <= 1'b0;
   endtask
   task automatic rdreg(input logic [7:0] a, input logic m);
      @(posedge ref_clk_in);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      sfr_rmw_in <= m;
      @(posedge ref_clk_in);
      sfr_rd_in <= 1'b0;
      sfr_rmw_in <= 1'b0;
      #1;
      rd = sfr_rdata_out;
   endtask
   // wait for reset entry, then exit, then read the cause flags
   task automatic settle(input string what, input int lim, input logic [7:0] exp);
      int i;
      for (i = 0; i < lim && sys_reset_out !== 1'b1; i++)
         tick(1);
      chk(what, {7'h00, sys_reset_out}, 8'h01);
      for (i = 0; i < 100 && sys_reset_out !== 1'b0; i++)
         tick(1);
      rdreg(rsf_pkg::RSF_REG_ADDR, 1'b0);
      chk(what, rd, exp);
   endtask
   task automatic wd(input logic [2:0] v);
      @(posedge ref_clk_in);
      {wdt_enable_in, wdt_disable_in, wdt_kick_in} <= v;
      @(posedge ref_clk_in);
      {wdt_enable_in, wdt_disable_in, wdt_kick_in} <= 3'h0;
   endtask
   // one flash access of kind k; r says whether a fault reset follows
   task automatic fl(input int k, input logic [15:0] a, input logic b, f, m, r);
      @(posedge ref_clk_in);
      {flash_size_64k_in, flash_write_enable_in, vdd_monitor_on_in} <= {b, f, m};
      external_move_op_addr_in <= a;
      code_read_op_addr_in <= a;
      branch_fetch_addr_in <= a;
      external_move_op_wr_in <= (k == 0);
      code_read_op_in <= (k == 1);
      branch_fetch_in <= (k == 2);
      flash_security_block_in <= (k == 3);
      flash_wr_erase_in <= (k == 4);
      @(posedge ref_clk_in);
      {external_move_op_wr_in, code_read_op_in, branch_fetch_in} <= 3'h0;
      {flash_write_enable_in, flash_security_block_in, flash_wr_erase_in} <= 3'h0;
      vdd_monitor_on_in <= 1'b1;
      if (r)
         settle("flash", 4, 8'h40);
      else
         quiet("flash", 4);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      settle("por", 1, 8'h02);
      chk("wdt on", {7'h00, wdt_running_out}, 8'h01);
      rdreg(8'h30, 1'b0);
      chk("unmapped", rd, 8'h00);
      // keep the supply source enabled while forcing
      wr(8'h12);
      settle("soft", 2, 8'h10);
      rdreg(rsf_pkg::RSF_REG_ADDR, 1'b1);
      chk("rmw soft", rd, 8'h02);
      wr(8'h02);
      quiet("no force", 4);
      fl(0, 16'h8000, 1'b0, 1'b1, 1'b1, 1'b1);
      fl(0, 16'hFC00, 1'b1, 1'b1, 1'b1, 1'b1);
      fl(0, 16'hFBFF, 1'b1, 1'b1, 1'b1, 1'b0);
      fl(0, 16'h8000, 1'b0, 1'b0, 1'b1, 1'b0);
      fl(1, 16'h7FFF, 1'b0, 1'b0, 1'b1, 1'b0);
      fl(1, 16'h8000, 1'b0, 1'b0, 1'b1, 1'b1);
      fl(2, 16'hFC00, 1'b1, 1'b0, 1'b1, 1'b1);
      fl(3, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b1);
      fl(4, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
      fl(4, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
      // bus power matching while the usb source is off must not reset
      @(posedge ref_clk_in);
      {vbus_in, bus_power_polarity_select_in} <= 2'h3;
      quiet("usb off", 6);
      @(posedge ref_clk_in);
      bus_power_polarity_select_in <= 1'b0;
      wr(8'h82);
      quiet("usb mismatch", 6);
      rdreg(rsf_pkg::RSF_REG_ADDR, 1'b1);
      chk("rmw usb", rd, 8'hC2);
      @(posedge ref_clk_in);
      bus_power_polarity_select_in <= 1'b1;
      settle("usb", 8, 8'h80);
      @(posedge ref_clk_in);
      vbus_in <= 1'b0;
      wr(8'h22);
      @(posedge ref_clk_in);
      comparator_out_in <= 1'b0;
      settle("cmp", 6, 8'h20);
      @(posedge ref_clk_in);
      comparator_out_in <= 1'b1;
      wr(8'h06);
      quiet("clock ok", 100);
      @(posedge ref_clk_in);
      sclk_run <= 1'b0;
      settle("clock loss", CLOCK_LOSS_DETECTOR + 10, 8'h04);
      sclk_run <= 1'b1;
      @(posedge ref_clk_in);
      pin_rst_n_in <= 1'b0;
      tick(6);
      @(posedge ref_clk_in);
      pin_rst_n_in <= 1'b1;
      settle("pin", 1, 8'h01);
      // one-cycle supply fault with the supply source still enabled
      @(posedge ref_clk_in);
      vdd_low_in <= 1'b1;
      @(posedge ref_clk_in);
      vdd_low_in <= 1'b0;
      settle("supply", 6, 8'h02);
      // kick lands two cycles after enable, so timing runs from the kick
      wd(3'h2);
      tick(2);
      chk("wdt off", {7'h00, wdt_running_out}, 8'h00);
      quiet("wdt off", 3200);
      wd(3'h4);
      wd(3'h1);
      quiet("wdt early", 12 * rsf_pkg::RSF_WDT_TICKS - 36);
      settle("wdt", 72, 8'h08);
      chk("wdt rearm", {7'h00, wdt_running_out}, 8'h01);
      end_sim();
   end
endmodule
`default_nettype wire
